//--- src/sysevt_pkg.sv
// Package: register map, field layout, states and carriers of the system event detector
package sysevt_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0]  OFF_EVT_EN    = 8'h00;
   localparam logic [7:0]  OFF_INIT_CNT  = 8'h04;
   localparam logic [7:0]  OFF_STATUS    = 8'h08;
   localparam logic [7:0]  OFF_MASK      = 8'h0c;
   localparam logic [7:0]  OFF_STATE     = 8'h10;

   // ****************************************
   // Fields and constants
   // ****************************************
   localparam int          IRQ_W         = 16;
   localparam logic [15:0] EVT_VALID     = 16'hfffa;
   localparam logic [15:0] EVT_EN_RST    = 16'h0000;
   localparam logic [15:0] INIT_CNT_DFLT = 16'hffff;
   localparam logic [15:0] CNT_ZERO      = 16'h0000;
   localparam logic [15:0] CNT_ONE       = 16'h0001;
   localparam int          ST_EVT        = 0;
   localparam int          ST_IDLE       = 1;
   localparam int          ST_W          = 2;
   localparam logic [1:0]  ST_RST        = 2'h0;
   localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
   localparam logic [3:0]  BE_ALL        = 4'hf;
   localparam int          REG_MSB       = 15;
   localparam int          PM_LSB        = 16;
   localparam int          PM_MSB        = 17;
   localparam int          STOPN_BIT     = 18;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      PM_RUN  = 2'b01,
      PM_IDLE = 2'b10
   } pm_state_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avs_req_t;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } avs_rsp_t;

   typedef struct packed {
      logic            cpu_stop_clock_n;
      logic            sys_mgmt_interrupt;
      logic            idle_state;
      logic            irq;
   } pm_out_t;

   typedef struct packed {
      logic [15:0]     evt_en;
      logic [15:0]     init_cnt;
      logic [15:0]     cnt;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      pm_state_t       pm;
      logic            stop_n;
      logic            mgmt_int;
      logic            irq;
      logic            wait_req;
      logic [31:0]     rdata;
   } core_state_t;

endpackage

//--- src/irq_sync.sv
// Two-stage synchroniser bank for the interrupt request pins
`timescale 1ns/1ps
`default_nettype none

module irq_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   // Pins and synchronised levels
   input  wire logic [W-1:0] pin_in,
   output var  logic [W-1:0] sync_out
);

   // ****************************************
   // Per-bit flip-flop pairs
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_r;
         logic hold_r;
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_r <= 1'b0;
               hold_r <= 1'b0;
            end else begin
               meta_r <= pin_in[g];
               hold_r <= meta_r;
            end
         end
         assign sync_out[g] = hold_r;
      end
   endgenerate

endmodule

`default_nettype wire

//--- src/irq_system_event_detect.sv
// Power-management system event detector with idle countdown and Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none

module irq_system_event_detect #(
   parameter logic [15:0] INIT_CNT_RST = sysevt_pkg::INIT_CNT_DFLT
) (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   // Interrupt request pins (bits 0, 2 and 8 unused)
   input  wire logic [15:0]         irq_lines,
   input  wire logic                rtc_irq_n_input,
   // Register bus
   input  wire sysevt_pkg::avs_req_t avs_req,
   output var  sysevt_pkg::avs_rsp_t avs_rsp,
   // Power management outputs
   output var  sysevt_pkg::pm_out_t  pm_out
);
   import sysevt_pkg::*;

   localparam core_state_t RST_VAL = '{
      evt_en:   EVT_EN_RST,
      init_cnt: INIT_CNT_RST,
      cnt:      INIT_CNT_RST,
      status:   ST_RST,
      mask:     ST_RST,
      pm:       PM_RUN,
      stop_n:   1'b1,
      mgmt_int: 1'b0,
      irq:      1'b0,
      wait_req: 1'b1,
      rdata:    RDATA_ZERO
   };

   core_state_t             r;
   core_state_t             n;
   logic [IRQ_W-1:0]        pin_vec;
   logic [IRQ_W-1:0]        sync_q;
   logic                    ev;
   logic                    acc_wr;
   logic                    acc_rd;
   logic [ST_W-1:0]         st_set;
   logic [ST_W-1:0]         st_clr;

   // ****************************************
   // Pin collection and synchronisation
   // ****************************************
   // The RTC line enters bit 8 as-is: event logic treats every line as active high
   assign pin_vec = {irq_lines[15:9], rtc_irq_n_input, irq_lines[7:0]};

   irq_sync #(
      .W        (IRQ_W)
   ) u_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .pin_in   (pin_vec),
      .sync_out (sync_q)
   );

   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      merge16 = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
   endfunction

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      n          = r;
      n.mgmt_int = 1'b0;
      st_set = ST_RST;
      st_clr = ST_RST;
      // Level sampling: a sustained high counts again every cycle
      ev     = |(sync_q & r.evt_en);
      acc_wr = avs_req.write && !r.wait_req;
      acc_rd = avs_req.read && !r.wait_req;
      if (ev) begin
         st_set[ST_EVT] = 1'b1;
      end
      case (r.pm)
         PM_RUN: begin
            if (ev) begin
               n.cnt    = r.init_cnt;
               n.stop_n = 1'b1;
            end else if (r.cnt == CNT_ZERO) begin
               n.pm            = PM_IDLE;
               n.stop_n        = 1'b0;
               n.mgmt_int      = 1'b1;
               st_set[ST_IDLE] = 1'b1;
            end else begin
               n.cnt = r.cnt - CNT_ONE;
            end
         end
         PM_IDLE: begin
            if (ev) begin
               n.pm     = PM_RUN;
               n.cnt    = r.init_cnt;
               n.stop_n = 1'b1;
            end
         end
         default: begin
            n.pm     = PM_RUN;
            n.stop_n = 1'b1;
         end
      endcase
      // Only bits that were actually returned are cleared, so a late set survives
      if (acc_rd && avs_req.address == OFF_STATUS) begin
         st_clr = r.rdata[ST_W-1:0];
      end
      n.status = (r.status & ~st_clr) | st_set;
      if (acc_wr) begin
         case (avs_req.address)
            OFF_EVT_EN: begin
               n.evt_en = merge16(r.evt_en, avs_req.writedata, avs_req.byteenable)
                          & EVT_VALID;
            end
            OFF_INIT_CNT: begin
               n.init_cnt = merge16(r.init_cnt, avs_req.writedata, avs_req.byteenable);
            end
            OFF_MASK: begin
               if (avs_req.byteenable[0]) begin
                  n.mask = avs_req.writedata[ST_W-1:0];
               end
            end
            default: begin
               n.mask = r.mask;
            end
         endcase
      end
      n.irq = |(n.status & n.mask);
      // One wait cycle: read data is captured while waitrequest is still high
      if (r.wait_req && (avs_req.read || avs_req.write)) begin
         n.wait_req = 1'b0;
         n.rdata    = RDATA_ZERO;
         if (avs_req.read) begin
            case (avs_req.address)
               OFF_EVT_EN:   n.rdata[REG_MSB:0] = r.evt_en;
               OFF_INIT_CNT: n.rdata[REG_MSB:0] = r.init_cnt;
               OFF_STATUS:   n.rdata[ST_W-1:0]  = n.status;
               OFF_MASK:     n.rdata[ST_W-1:0]  = r.mask;
               OFF_STATE: begin
                  n.rdata[REG_MSB:0]     = r.cnt;
                  n.rdata[PM_MSB:PM_LSB] = r.pm;
                  n.rdata[STOPN_BIT]     = r.stop_n;
               end
               default:      n.rdata = RDATA_ZERO;
            endcase
         end
      end else begin
         n.wait_req = 1'b1;
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= RST_VAL;
      end else begin
         r <= n;
      end
   end

   assign avs_rsp.waitrequest        = r.wait_req;
   assign avs_rsp.readdata           = r.rdata;
   assign pm_out.cpu_stop_clock_n    = r.stop_n;
   assign pm_out.sys_mgmt_interrupt  = r.mgmt_int;
   assign pm_out.idle_state          = r.pm == PM_IDLE;
   assign pm_out.irq                 = r.irq;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   property p_en_write;
      acc_wr && avs_req.address == OFF_EVT_EN && avs_req.byteenable == BE_ALL
      |=> r.evt_en == ($past(avs_req.writedata[15:0]) & EVT_VALID);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write lost");

   property p_reload;
      ev |=> r.cnt == $past(r.init_cnt) && r.stop_n && r.pm == PM_RUN;
   endproperty
   a_reload: assert property (p_reload) else $error("event did not reload");

   property p_level;
      $past(rst_b, 2) |-> ev == |($past(pin_vec, 2) & r.evt_en);
   endproperty
   a_level: assert property (p_level) else $error("level sample mismatch");

   property p_hold_high;
      ev [*2] |-> pm_out.cpu_stop_clock_n && !pm_out.sys_mgmt_interrupt
                  && !pm_out.idle_state;
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("idle while event held");

   property p_no_reload;
      !ev && r.pm == PM_RUN && r.cnt != CNT_ZERO |=> r.cnt == $past(r.cnt) - CNT_ONE;
   endproperty
   a_no_reload: assert property (p_no_reload) else $error("disabled line reloaded");

   property p_terminal;
      !ev && r.pm == PM_RUN && r.cnt == CNT_ZERO
      |=> pm_out.idle_state && !pm_out.cpu_stop_clock_n && pm_out.sys_mgmt_interrupt
          ##1 !pm_out.sys_mgmt_interrupt;
   endproperty
   a_terminal: assert property (p_terminal) else $error("terminal count missed");

   property p_irq;
      pm_out.irq == |(r.status & r.mask);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt output wrong");

   property p_wait;
      !avs_rsp.waitrequest |=> avs_rsp.waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("waitrequest low too long");

   c_event:  cover property (ev ##1 !ev);
   c_idle:   cover property (r.pm == PM_IDLE ##[1:20] r.pm == PM_RUN);
   c_stread: cover property (acc_rd && avs_req.address == OFF_STATUS && r.rdata != RDATA_ZERO);
   c_irq:    cover property (!pm_out.irq ##1 pm_out.irq);

endmodule

`default_nettype wire

//--- dv/irq_src_model.sv
// Partner model: interrupt sources facing the system event detector
`timescale 1ns/1ps
`default_nettype none

module irq_src_model (
   // Requests from the bench
   input  wire logic [15:0] req,
   // Pins toward the detector
   output logic      [15:0] irq_lines,
   output logic             rtc_irq_n_input
);
   // ****************************************
   // Driven sources
   // ****************************************
   // Sources always drive low when idle; a floated line would keep the timer awake
   assign irq_lines       = req & 16'hfeff;
   assign rtc_irq_n_input = req[8];
endmodule

`default_nettype wire

//--- dv/tb_irq_system_event_detect.sv
// Self-checking bench for the system event detector
`timescale 1ns/1ps
`default_nettype none

module tb_irq_system_event_detect;
   import sysevt_pkg::*;
   // Short count keeps each idle entry a few cycles away
   localparam logic [15:0] INIT = 16'h0008;
   logic        core_clk        = 1'b0;
   logic        rst_b           = 1'b0;
   logic [15:0] req             = 16'h0000;
   logic [15:0] irq_lines;
   logic        rtc_irq_n_input;
   avs_req_t    avs_req         = '0;
   avs_rsp_t    avs_rsp;
   pm_out_t     pm_out;
   int          fails           = 0;
   int          samples_checked = 0;
   int          cyc             = 0;
   int          mgmt_cnt        = 0;
   logic [31:0] q;

   always #12.5 core_clk = ~core_clk;

   irq_src_model src (
      .req             (req),
      .irq_lines       (irq_lines),
      .rtc_irq_n_input (rtc_irq_n_input)
   );

   irq_system_event_detect #(.INIT_CNT_RST(INIT)) dut (
      .core_clk        (core_clk),
      .rst_b           (rst_b),
      .irq_lines       (irq_lines),
      .rtc_irq_n_input (rtc_irq_n_input),
      .avs_req         (avs_req),
      .avs_rsp         (avs_rsp),
      .pm_out          (pm_out)
   );

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic summarize();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low, then releases it
   // A missing answer is left to the bench timeout, never to a local limit
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: BE_ALL};
      do begin
         @(posedge core_clk);
      end while (avs_rsp.waitrequest !== 1'b0);
      q = avs_rsp.readdata;
      avs_req.read  <= 1'b0;
      avs_req.write <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic pins(input logic [15:0] v);
      @(posedge core_clk);
      req <= v;
   endtask

   // Compares stop-clock release and idle level together
   task automatic pm(input logic [1:0] exp);
      chk({30'h0, pm_out.cpu_stop_clock_n, pm_out.idle_state}, {30'h0, exp});
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (pm_out.sys_mgmt_interrupt === 1'b1)
         mgmt_cnt <= mgmt_cnt + 1;
      if (cyc == 20000) begin
         fails++;
         $display("CHECK FAILED at %0t: timeout", $time);
         summarize();
      end
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      int i;
      int s0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(OFF_EVT_EN, 32'h0);
      rd(OFF_INIT_CNT, {16'h0, INIT});
      wait_cyc(12);
      pm(2'b01);
      $display("test reset done");
      bus(1'b1, OFF_EVT_EN, 32'hffff);
      rd(OFF_EVT_EN, {16'h0, EVT_VALID});
      bus(1'b1, 8'h20, 32'h1234);
      rd(8'h20, 32'h0);
      rd(OFF_EVT_EN, {16'h0, EVT_VALID});
      $display("test enable map done");
      bus(1'b1, OFF_INIT_CNT, 32'h3);
      for (i = 0; i < 16; i++) begin
         if (EVT_VALID[i]) begin
            bus(1'b1, OFF_EVT_EN, 32'h1 << i);
            pins(16'hffff & ~(16'h1 << i));
            wait_cyc(10);
            pm(2'b01);
            s0 = mgmt_cnt;
            pins(16'hffff);
            wait_cyc(30);
            pm(2'b10);
            rd(OFF_STATE, 32'h0005_0003);
            pins(16'h0000);
            wait_cyc(12);
            pm(2'b01);
            chk(32'(mgmt_cnt - s0), 32'h1);
         end
      end
      $display("test event lines done");
      bus(1'b1, OFF_EVT_EN, 32'hfffa);
      for (i = 0; i < 2; i++) begin
         bus(1'b1, OFF_MASK, (i == 0) ? 32'h2 : 32'h0);
         bus(1'b0, OFF_STATUS, 32'h0);
         wait_cyc(2);
         chk({31'h0, pm_out.irq}, 32'h0);
         pins(16'h0008);
         wait_cyc(6);
         pins(16'h0000);
         wait_cyc(12);
         chk({31'h0, pm_out.irq}, {31'h0, (i == 0)});
         rd(OFF_STATUS, 32'h3);
         wait_cyc(2);
         chk({31'h0, pm_out.irq}, 32'h0);
      end
      $display("test interrupt done");
      summarize();
   end
endmodule

`default_nettype wire
